// File: pwmp_checker.sv
/* checker on the ports of pwmp_top.
   assumes ce held high and a single ahb-lite master. */
`timescale 1ns/100ps
module pwmp_checker (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        pwm_out_first,
    input wire        pwm_out_second,
    input wire        pwm_interrupt
);
    wire rd_now = hsel && hready && htrans[1] && !hwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence rd_take;
        rd_now;
    endsequence
    ready_always_a: assert property (hreadyout)
        else $error("ready went low");
    resp_okay_a: assert property (!hresp)
        else $error("error response");
    irq_pulse_a: assert property (pwm_interrupt |=> !pwm_interrupt)
        else $error("interrupt wider than one cycle");
    rdata_hold_a: assert property (!rd_now |=> $stable(hrdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_take ##0 (haddr > 32'h3B)
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    byte_upper_a: assert property (rd_take ##0 (haddr[31:3] == 29'h0)
        |=> hrdata[31:8] == 24'h0) else $error("counter byte too wide");
    buf_upper_a: assert property (rd_take ##0 (haddr >= 32'h2C)
        ##0 (haddr <= 32'h38) |=> hrdata[31:16] == 16'h0)
        else $error("buffer wider than 16 bits");
    status_bits_a: assert property (rd_take ##0 (haddr == 32'h20)
        |=> hrdata[31:5] == 27'h0) else $error("control bits too wide");
    reset_outs_a: assert property (disable iff (1'b0) !rst_n
        |=> pwm_out_first && pwm_out_second && !pwm_interrupt)
        else $error("outputs wrong after reset");
endmodule

bind pwmp_top pwmp_checker u_chk (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .hrdata, .pwm_out_first,
    .pwm_out_second, .pwm_interrupt);

// File: pwmp_clk_sel.v
/*
 * pwm count clock selection: one-cycle tick per falling edge of the
 * selected pwm clock, from a divider of sys_clk or an external pin.
 * assumes the pin is asynchronous and slower than sys_clk / 2.
 */
`timescale 1ns/100ps
`include "pwmp_defs.vh"
module pwmp_clk_sel (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire [1:0] sel,
    input  wire       ext_pin,
    output reg        tick
);
    reg [2:0] div;
    reg       sync_a;
    reg       sync_b;
    reg       last_b;
    reg       next_tick;

    always @* begin
        case (sel)
            `PWMP_CK_DIV2: next_tick = (div[0] == 1'b1);
            `PWMP_CK_DIV4: next_tick = (div[1:0] == 2'h3);
            `PWMP_CK_DIV8: next_tick = (div == 3'h7);
            default:       next_tick = last_b & ~sync_b;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            div    <= 3'h0;
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last_b <= 1'b0;
            tick   <= 1'b0;
        end else if (ce) begin
            div    <= div + 3'h1;
            sync_a <= ext_pin;
            sync_b <= sync_a;
            last_b <= sync_b;
            tick   <= next_tick;
        end
    end
endmodule

// File: pwmp_defs.vh
/*
 * constants for the paired pwm block: register offsets, field positions,
 * reset values and clock selections.
 * assumes byte addresses on a 32-bit ahb-lite bus, one register a word.
 */
// Summary of operation
// [R1] - run set: status rises on first pwm clock edge, counting on second
// [R2] - pair mode needs link=1, dead time=0; oneshot select 0 repeat, 1 one-shot
// [R3] - counter equals first duty buffer: first flag 0 next edge
// [R4] - counter equals second duty buffer: second flag 0 next edge
// [R5] - counter equals second period buffer: second flag 1 next edge
// [R6] - repeat: period match sets first flag, clears counter, keeps counting
// [R7] - one-shot: period match sets flag, clears counter, stops, clears run
// [R8] - period match copies duty and period registers into buffers
// [R9] - run cleared: one more edge counted, then status clears; software polls
// [R10] - run set again resumes from the held counter value
// [R11] - write to either counter byte clears counter, sets first flag
// [R12] - while stopped, duty and period writes go straight into buffers
// [R13] - control 0 regs pick clock, interrupt point, output polarities
// [R14] - external input may start, stop, clear counter and outputs
// [R15] - period lasts value+1 clocks, duties value+1 clocks
// [R16] - software keeps period 0001H..0FFFFH, duty 0000H..0FFFEH
// [R17] - first interrupt may be one clock late, later ones periodic
// [R18] - interrupt may still occur on the final edge after run clears
// [R19] - counter and buffers 16 bits, counter read as two bytes
// [R20] - each pin shows its flag, inverted by its polarity bit
`ifndef PWMP_DEFS_VH
`define PWMP_DEFS_VH

`define PWMP_A_CNT_LO      4'h0
`define PWMP_A_CNT_HI      4'h1
`define PWMP_A_DUTY1       4'h2
`define PWMP_A_PER1        4'h3
`define PWMP_A_DUTY2       4'h4
`define PWMP_A_PER2        4'h5
`define PWMP_A_CTRL0_1     4'h6
`define PWMP_A_CTRL0_2     4'h7
`define PWMP_A_RUNSTAT     4'h8
`define PWMP_A_TRIG        4'h9
`define PWMP_A_FLAGS       4'hA
`define PWMP_A_DBUF1       4'hB
`define PWMP_A_PBUF1       4'hC
`define PWMP_A_DBUF2       4'hD
`define PWMP_A_PBUF2       4'hE

// control 0 of first channel
`define PWMP_C0_CLK_LO     0
`define PWMP_C0_CLK_HI     1
`define PWMP_C0_INTPT      2
`define PWMP_C0_POL        3
// control 0 of second channel
`define PWMP_C2_POL        0
// run and status
`define PWMP_RS_RUN        0
`define PWMP_RS_ONESHOT    1
`define PWMP_RS_STAT       2
`define PWMP_RS_LINK       3
`define PWMP_RS_DTEN       4
// external trigger control
`define PWMP_TG_MODE_LO    0
`define PWMP_TG_MODE_HI    1
`define PWMP_TG_EDGE_A     2
`define PWMP_TG_EDGE_B     3
`define PWMP_TG_PIN        4

`define PWMP_TGM_OFF       2'h0
`define PWMP_TGM_START     2'h1
`define PWMP_TGM_STOP      2'h2
`define PWMP_TGM_CLRSTART  2'h3

`define PWMP_EDGE_RISE     2'h0
`define PWMP_EDGE_FALL     2'h1
`define PWMP_EDGE_BOTH     2'h2
`define PWMP_EDGE_LEVEL    2'h3

`define PWMP_CK_DIV2       2'h0
`define PWMP_CK_DIV4       2'h1
`define PWMP_CK_DIV8       2'h2
`define PWMP_CK_EXT        2'h3

`define PWMP_CNT_CLEAR     16'h0000
`define PWMP_RST_DUTY      16'h0000
`define PWMP_RST_PERIOD    16'hFFFF
`define PWMP_RST_FLAG      1'b1

`endif

// File: pwmp_load.sv
/* load model on the two pwm pins: measures high time and period of
   the first pin and low time of the second, in sys_clk cycles.
   assumes pins change on sys_clk edges. */
`timescale 1ns/100ps
module pwmp_load (
    input  wire sys_clk,
    input  wire pin_a,
    input  wire pin_b,
    output int  hi_a,
    output int  per_a,
    output int  lo_b
);
    int   ca = 0;
    int   cb = 0;
    logic pa = 1'b0;
    logic pb = 1'b0;
    always @(posedge sys_clk) begin
        ca <= ca + 1;
        cb <= cb + 1;
        pa <= pin_a;
        pb <= pin_b;
        if (pin_a && !pa) begin // period and duty widths
            per_a <= ca;
            ca    <= 1;
        end
        if (!pin_a && pa) hi_a <= ca;
        if (!pin_b && pb) cb <= 1;
        if (pin_b && !pb) lo_b <= cb;
    end
endmodule

// File: pwmp_top.v
/*
 * paired pwm generator: shared 16-bit counter, two linked outputs
 * without dead time, repeat and one-shot modes, double-buffered duty
 * and period, external start/stop/clear, ahb-lite register slave.
 * assumes a single ahb-lite master and whole-word transfers.
 */
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "pwmp_defs.vh"
module pwmp_top (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire        pwm_clk_pin,
    input  wire        trig_pin_a,
    input  wire        trig_pin_b,
    output reg         pwm_out_first,
    output reg         pwm_out_second,
    output reg         pwm_interrupt
);
    // counter and buffers
    reg [15:0] cnt;
    reg [15:0] duty1_reg;
    reg [15:0] per1_reg;
    reg [15:0] duty2_reg;
    reg [15:0] per2_reg;
    reg [15:0] first_duty_buffer;
    reg [15:0] first_period_buffer;
    reg [15:0] second_duty_buffer;
    reg [15:0] second_period_buffer;
    // control
    reg [1:0]  clk_select;
    reg        int_point;
    reg        pol_first;
    reg        pol_second;
    reg        run_bit;
    reg        counting_status;
    reg        oneshot_select;
    reg        pair_link_mode;
    reg        dead_time_enable;
    reg        ext_ctrl_mode_lo;
    reg        ext_ctrl_mode_hi;
    reg        trigger_edge_sel_a;
    reg        trigger_edge_sel_b;
    reg        trigger_pin_select;
    reg        first_output_flag;
    reg        second_output_flag;
    // bus address phase
    reg        ap_write;
    reg [3:0]  ap_index;
    reg        ap_mapped;
    reg [31:0] read_mux;

    wire       pwm_count_clock;
    wire       trig_event;
    wire       ap_take;
    wire       wr_en;
    wire       pair_active;
    wire       per1_match;
    wire [1:0] ext_mode;

    function [3:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[5:2];
        end
    endfunction

    function mapped;
        input [31:0] addr;
        begin
            mapped = (addr[31:6] == 26'h0) &&
                     (addr[5:2] <= `PWMP_A_PBUF2);
        end
    endfunction

    pwmp_clk_sel u_clk (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .sel     (clk_select),
        .ext_pin (pwm_clk_pin),
        .tick    (pwm_count_clock)
    );

    pwmp_trig u_trig (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .pin_sel   (trigger_pin_select),
        .edge_sel  ({trigger_edge_sel_b, trigger_edge_sel_a}),
        .pin_a     (trig_pin_a),
        .pin_b     (trig_pin_b),
        .event_out (trig_event)
    );

    assign ap_take     = hsel & htrans[1] & hready;
    assign wr_en       = ap_write & ap_mapped;
    assign pair_active = pair_link_mode & ~dead_time_enable; // [R2]
    assign per1_match  = (cnt == first_period_buffer);
    assign ext_mode    = {ext_ctrl_mode_hi, ext_ctrl_mode_lo};

    // register read mux
    always @* begin
        read_mux = 32'h0000_0000;
        case (word_index(haddr))
            `PWMP_A_CNT_LO:  read_mux[7:0]  = cnt[7:0];  // [R19]
            `PWMP_A_CNT_HI:  read_mux[7:0]  = cnt[15:8]; // [R19]
            `PWMP_A_DUTY1:   read_mux[15:0] = duty1_reg;
            `PWMP_A_PER1:    read_mux[15:0] = per1_reg;
            `PWMP_A_DUTY2:   read_mux[15:0] = duty2_reg;
            `PWMP_A_PER2:    read_mux[15:0] = per2_reg;
            `PWMP_A_CTRL0_1: read_mux[3:0]  = {pol_first, int_point,
                                               clk_select};
            `PWMP_A_CTRL0_2: read_mux[0]    = pol_second;
            `PWMP_A_RUNSTAT: read_mux[4:0]  = {dead_time_enable,
                                               pair_link_mode,
                                               counting_status,
                                               oneshot_select,
                                               run_bit}; // [R9]
            `PWMP_A_TRIG:    read_mux[4:0]  = {trigger_pin_select,
                                               trigger_edge_sel_b,
                                               trigger_edge_sel_a,
                                               ext_ctrl_mode_hi,
                                               ext_ctrl_mode_lo};
            `PWMP_A_FLAGS:   read_mux[1:0]  = {second_output_flag,
                                               first_output_flag};
            `PWMP_A_DBUF1:   read_mux[15:0] = first_duty_buffer;
            `PWMP_A_PBUF1:   read_mux[15:0] = first_period_buffer;
            `PWMP_A_DBUF2:   read_mux[15:0] = second_duty_buffer;
            `PWMP_A_PBUF2:   read_mux[15:0] = second_period_buffer;
            default:         read_mux = 32'h0000_0000;
        endcase
        if (!mapped(haddr)) begin
            read_mux = 32'h0000_0000;
        end
    end

    // ahb-lite slave: zero wait, always okay
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
            ap_write  <= 1'b0;
            ap_index  <= 4'h0;
            ap_mapped <= 1'b0;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                ap_write  <= ap_take & hwrite;
                ap_index  <= word_index(haddr);
                ap_mapped <= ap_take & mapped(haddr);
                if (ap_take && !hwrite) begin
                    hrdata <= read_mux;
                end
            end
        end
    end

    // counter, flags, buffers and control
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt                  <= `PWMP_CNT_CLEAR;
            duty1_reg            <= `PWMP_RST_DUTY;
            per1_reg             <= `PWMP_RST_PERIOD;
            duty2_reg            <= `PWMP_RST_DUTY;
            per2_reg             <= `PWMP_RST_PERIOD;
            first_duty_buffer    <= `PWMP_RST_DUTY;
            first_period_buffer  <= `PWMP_RST_PERIOD;
            second_duty_buffer   <= `PWMP_RST_DUTY;
            second_period_buffer <= `PWMP_RST_PERIOD;
            clk_select           <= `PWMP_CK_DIV2;
            int_point            <= 1'b0;
            pol_first            <= 1'b0;
            pol_second           <= 1'b0;
            run_bit              <= 1'b0;
            counting_status      <= 1'b0;
            oneshot_select       <= 1'b0;
            pair_link_mode       <= 1'b0;
            dead_time_enable     <= 1'b0;
            ext_ctrl_mode_lo     <= 1'b0;
            ext_ctrl_mode_hi     <= 1'b0;
            trigger_edge_sel_a   <= 1'b0;
            trigger_edge_sel_b   <= 1'b0;
            trigger_pin_select   <= 1'b0;
            first_output_flag    <= `PWMP_RST_FLAG;
            second_output_flag   <= `PWMP_RST_FLAG;
            pwm_interrupt        <= 1'b0;
        end else if (ce) begin
            pwm_interrupt <= 1'b0;
            if (pwm_count_clock) begin
                if (!counting_status) begin
                    if (run_bit) begin
                        counting_status <= 1'b1; // [R1] [R10]
                    end
                end else begin
                    // one counting step per pwm clock edge [R1] [R15]
                    if (!run_bit) begin
                        counting_status <= 1'b0; // [R9]
                    end
                    if (cnt == first_duty_buffer) begin
                        first_output_flag <= 1'b0; // [R3]
                        if (int_point) begin
                            pwm_interrupt <= 1'b1; // [R13] [R18]
                        end
                    end
                    if (pair_active) begin
                        if (cnt == second_duty_buffer) begin
                            second_output_flag <= 1'b0; // [R4]
                        end
                        if (cnt == second_period_buffer) begin
                            second_output_flag <= 1'b1; // [R5]
                        end
                    end
                    if (per1_match) begin
                        first_output_flag    <= 1'b1; // [R6]
                        cnt                  <= `PWMP_CNT_CLEAR; // [R6]
                        first_duty_buffer    <= duty1_reg; // [R8]
                        first_period_buffer  <= per1_reg;  // [R8]
                        second_duty_buffer   <= duty2_reg; // [R8]
                        second_period_buffer <= per2_reg;  // [R8]
                        if (!int_point) begin
                            pwm_interrupt <= 1'b1; // [R17] [R18]
                        end
                        if (oneshot_select) begin
                            run_bit         <= 1'b0; // [R7]
                            counting_status <= 1'b0; // [R7]
                        end
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
            end
            // external start, stop and clear [R14]
            if (trig_event) begin
                case (ext_mode)
                    `PWMP_TGM_START: begin
                        run_bit <= 1'b1;
                    end
                    `PWMP_TGM_STOP: begin
                        run_bit <= 1'b0;
                    end
                    `PWMP_TGM_CLRSTART: begin
                        run_bit            <= 1'b1;
                        cnt                <= `PWMP_CNT_CLEAR;
                        first_output_flag  <= 1'b1;
                        second_output_flag <= 1'b1;
                    end
                    default: begin
                        run_bit <= run_bit;
                    end
                endcase
            end
            // software writes come last and take priority
            if (wr_en) begin
                case (ap_index)
                    `PWMP_A_CNT_LO, `PWMP_A_CNT_HI: begin
                        cnt               <= `PWMP_CNT_CLEAR; // [R11]
                        first_output_flag <= 1'b1; // [R11]
                    end
                    `PWMP_A_DUTY1: begin
                        duty1_reg <= hwdata[15:0];
                        if (!run_bit) begin
                            first_duty_buffer <= hwdata[15:0]; // [R12]
                        end
                    end
                    `PWMP_A_PER1: begin
                        per1_reg <= hwdata[15:0];
                        if (!run_bit) begin
                            first_period_buffer <= hwdata[15:0]; // [R12]
                        end
                    end
                    `PWMP_A_DUTY2: begin
                        duty2_reg <= hwdata[15:0];
                        if (!run_bit) begin
                            second_duty_buffer <= hwdata[15:0]; // [R12]
                        end
                    end
                    `PWMP_A_PER2: begin
                        per2_reg <= hwdata[15:0];
                        if (!run_bit) begin
                            second_period_buffer <= hwdata[15:0]; // [R12]
                        end
                    end
                    `PWMP_A_CTRL0_1: begin
                        clk_select <= hwdata[`PWMP_C0_CLK_HI:
                                             `PWMP_C0_CLK_LO]; // [R13]
                        int_point  <= hwdata[`PWMP_C0_INTPT];
                        pol_first  <= hwdata[`PWMP_C0_POL];
                    end
                    `PWMP_A_CTRL0_2: begin
                        pol_second <= hwdata[`PWMP_C2_POL]; // [R13]
                    end
                    `PWMP_A_RUNSTAT: begin
                        run_bit          <= hwdata[`PWMP_RS_RUN];
                        oneshot_select   <= hwdata[`PWMP_RS_ONESHOT];
                        pair_link_mode   <= hwdata[`PWMP_RS_LINK];
                        dead_time_enable <= hwdata[`PWMP_RS_DTEN];
                    end
                    `PWMP_A_TRIG: begin
                        ext_ctrl_mode_lo   <= hwdata[`PWMP_TG_MODE_LO];
                        ext_ctrl_mode_hi   <= hwdata[`PWMP_TG_MODE_HI];
                        trigger_edge_sel_a <= hwdata[`PWMP_TG_EDGE_A];
                        trigger_edge_sel_b <= hwdata[`PWMP_TG_EDGE_B];
                        trigger_pin_select <= hwdata[`PWMP_TG_PIN];
                    end
                    default: begin
                        cnt <= cnt;
                    end
                endcase
            end
        end
    end

    // output pins
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pwm_out_first  <= `PWMP_RST_FLAG;
            pwm_out_second <= `PWMP_RST_FLAG;
        end else if (ce) begin
            pwm_out_first  <= first_output_flag ^ pol_first;   // [R20]
            pwm_out_second <= second_output_flag ^ pol_second; // [R20]
        end
    end
endmodule

// File: pwmp_top_tb.sv
/* self-checking bench for pwmp_top over ahb-lite.
   assumes zero wait states are not relied on; ce held high. */
`timescale 1ns/100ps
module pwmp_top_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        pin_clk = 1'b0;
    logic [1:0]  tpin = 2'h0;
    wire         hready;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         out1;
    wire         out2;
    wire         irq;
    int          hi_a, per_a, lo_b, n, pc;
    int          n_mismatch = 0;
    int          comparisons = 0;
    logic [31:0] v, v1;
    int ra[5] = '{8'h08, 8'h0C, 8'h30, 8'h28, 8'h20};
    int re[5] = '{16'h0000, 16'hFFFF, 16'hFFFF, 3, 0};
    int wv[4] = '{2, 5, 1, 4};
    int mult[5] = '{2, 4, 8, 10, 2};
    int tc[3] = '{8'h0D, 8'h16, 8'h0B};
    int tp[3] = '{0, 1, 0};
    int tr[3] = '{1, 0, 1};
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        pc <= (pc >= 4) ? 0 : pc + 1;
        if (pc >= 4) pin_clk <= ~pin_clk;
    end
    pwmp_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .pwm_clk_pin(pin_clk), .trig_pin_a(tpin[0]),
        .trig_pin_b(tpin[1]), .pwm_out_first(out1), .pwm_out_second(out2),
        .pwm_interrupt(irq));
    pwmp_load LOAD (.sys_clk(sys_clk), .pin_a(out1), .pin_b(out2),
        .hi_a(hi_a), .per_a(per_a), .lo_b(lo_b));
    task summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task done(input string s);
        $display("test %0s done", s);
    endtask
    task dph;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
    endtask
    task aph(input logic [31:0] a, input logic w);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        dph;
        hsel   <= 1'b0;
        htrans <= 2'h0;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        dph;
    endtask
    task rd(input logic [31:0] a, output logic [31:0] d);
        aph(a, 1'b0);
        dph;
        d = hrdata;
    endtask
    task wirq;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (irq !== 1'b1 && n < 3000);
        if (n >= 3000) chk(0, 1);
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], v);
            chk(v, re[i]); // reset contents
        end
        done("reset");
        for (int i = 0; i < 4; i++) begin
            wr(32'h08 + 4 * i, wv[i]); // legal values
            rd(32'h2C + 4 * i, v);
            chk(v, wv[i]); // buffer follows while stopped
        end
        done("buffers");
        wr(32'h00, 0);
        wr(32'h20, 32'h09);
        repeat (3) wirq;
        chk(per_a, 12); // period length
        chk(hi_a, 6); // first high part
        chk(lo_b, 6); // second low part
        for (int s = 0; s < 5; s++) begin
            wr(32'h18, (s == 4) ? 4 : s);
            repeat (3) wirq;
            chk(n, 6 * mult[s]); // steady interrupt spacing
            chk(out1, s == 4); // interrupt at duty or period match
        end
        wr(32'h18, 0);
        wirq;
        wr(32'h08, 1);
        rd(32'h2C, v);
        chk(v, 2); // buffer held while running
        wirq;
        rd(32'h2C, v);
        chk(v, 1); // loaded at period match
        wirq;
        chk(hi_a, 4); // new duty in use
        done("repeat");
        wr(32'h20, 32'h08);
        v = 32'hF;
        for (n = 0; n < 20 && v[2] !== 1'b0; n++) rd(32'h20, v);
        chk(v & 32'h4, 0); // status drops
        rd(32'h00, v1);
        repeat (30) @(posedge sys_clk);
        rd(32'h00, v);
        chk(v, v1); // counter held
        done("stop");
        wr(32'h00, 0);
        wr(32'h20, 32'h0B);
        wirq;
        repeat (4) @(posedge sys_clk);
        rd(32'h20, v);
        chk(v, 32'h0A); // run and status cleared
        rd(32'h00, v);
        chk(v, 0); // counter cleared
        done("oneshot");
        wr(32'h18, 32'h08);
        wr(32'h1C, 32'h01);
        wr(32'h04, 0);
        repeat (3) @(posedge sys_clk);
        chk(out1, 0); // flag set, pin inverted
        rd(32'h28, v);
        chk(v & 32'h1, 1); // flag set by counter write
        wr(32'h18, 0);
        wr(32'h1C, 0);
        done("polarity");
        wr(32'h20, 32'h08);
        for (int i = 0; i < 3; i++) begin
            wr(32'h24, tc[i]);
            tpin[tp[i]] <= 1'b1;
            repeat (10) @(posedge sys_clk);
            tpin <= 2'h0;
            repeat (10) @(posedge sys_clk);
            rd(32'h20, v);
            chk(v & 32'h1, tr[i]); // external start and stop
        end
        wr(32'h24, 0);
        wr(32'h20, 32'h08);
        done("trigger");
        wr(32'h40, 32'hFFFF);
        rd(32'h3C, v);
        chk(v, 0);
        rd(32'h40, v);
        chk(v, 0);
        rd(32'h0C, v);
        chk(v, 5);
        done("unmapped");
        summarize;
    end
    initial begin
        #2000000;
        n_mismatch++;
        summarize;
    end
endmodule

// File: pwmp_trig.v
/*
 * external start/stop/clear input: pin select, synchronisers and
 * edge or level detection, giving a one-cycle event per edge, or an event held high for as long as the level is high.
 * assumes asynchronous pins.
 */
`timescale 1ns/100ps
`include "pwmp_defs.vh"
module pwmp_trig (
    input  wire       sys_clk,
    input  wire       rst_n,
    input  wire       ce,
    input  wire       pin_sel,
    input  wire [1:0] edge_sel,
    input  wire       pin_a,
    input  wire       pin_b,
    output reg        event_out
);
    reg [1:0] sync_a;
    reg [1:0] sync_b;
    reg       last;
    reg       cur;
    reg       next_event;

    always @* begin
        cur = pin_sel ? sync_b[1] : sync_a[1];
        case (edge_sel)
            `PWMP_EDGE_RISE:  next_event = cur & ~last;
            `PWMP_EDGE_FALL:  next_event = ~cur & last;
            `PWMP_EDGE_BOTH:  next_event = cur ^ last;
            default:          next_event = cur;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            sync_a    <= 2'h0;
            sync_b    <= 2'h0;
            last      <= 1'b0;
            event_out <= 1'b0;
        end else if (ce) begin
            sync_a    <= {sync_a[0], pin_a};
            sync_b    <= {sync_b[0], pin_b};
            last      <= cur;
            event_out <= next_event;
        end
    end
endmodule
